//--- hdl/cpm_pkg.sv
package cpm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [9:0] ADDR_PLL_CTRL = 10'h010;
    localparam logic [9:0] ADDR_DIST_SRC = 10'h1e1;

    // Field positions
    localparam int PLL_PWR_LSB   = 0;
    localparam int CP_MODE_LSB   = 2;
    localparam int PFD_POL_BIT   = 7;
    localparam int BYPASS_BIT    = 0;
    localparam int SRC_SEL_BIT   = 1;

    // Power field codes
    localparam logic [1:0] PWR_NORMAL     = 2'h0;
    localparam logic [1:0] PWR_ASYNC_DOWN = 2'h1;

    // Reset values: PLL off, divider in path, external clock selected; the src_ext_clk output flop itself resets to 0 while rst is high
    localparam logic [7:0] RST_PLL_CTRL = 8'h01;
    localparam logic [7:0] RST_DIST_SRC = 8'h00;

    // Nonvolatile store layout
    localparam int         NV_WORDS     = 2;
    localparam logic [0:0] NV_IDX_PLL   = 1'h0;
    localparam logic [0:0] NV_IDX_DIST  = 1'h1;

    typedef enum logic [1:0] {
        ST_LOAD0 = 2'b00,
        ST_LOAD1 = 2'b01,
        ST_RUN   = 2'b10,
        ST_SAVE1 = 2'b11
    } cpm_state_type;

    typedef struct packed {
        logic       pll_enable;
        logic       pll_power_down;
        logic [1:0] cp_mode;
        logic       pfd_negative;
        logic       div_bypass;
        logic       src_ext_clk;
    } cpm_ctrl_type;

endpackage : cpm_pkg

//--- hdl/cpm_nvstore.sv
module cpm_nvstore (
    input  wire logic       clk,
    input  wire logic       we,
    input  wire logic [0:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);
    // Holds contents across rst; models the on-board store
    logic [7:0] mem [cpm_pkg::NV_WORDS];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : cpm_nvstore

//--- hdl/cpm_clock_path.sv
// Summary of operation
// - Saved configuration restored at power-up automatically
// - Power field 01 powers PLL down asynchronously
// - Power field 00 runs PLL normally
// - Bypass bit 1 feeds distribution directly
// - Source bit 0 selects external clock input
// - Polarity bit 0 positive, 1 negative sense
// - Bypass bit 0 routes through VCO divider
module cpm_clock_path (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 wr_en,
    input  wire logic                 rd_en,
    input  wire logic [9:0]           addr,
    input  wire logic [7:0]           wdata,
    input  wire logic                 nv_save,
    input  wire logic                 nv_valid,
    output logic      [7:0]           rdata,
    output logic                      busy,
    output cpm_pkg::cpm_ctrl_type     ctrl
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]             pll_ctrl_reg;
    logic [7:0]             dist_src_reg;
    cpm_pkg::cpm_state_type state_reg;
    logic                   nv_we;
    logic [0:0]             nv_addr;
    logic [7:0]             nv_wdata;
    logic [7:0]             nv_rdata;
    logic                   nv_valid_meta;
    logic                   nv_valid_sync;
    logic                   wr_ok;
    logic                   pll_on_reg;
    logic                   pll_off_reg;
    logic [1:0]             pump_mode_reg;
    logic                   pol_neg_reg;
    logic                   bypass_reg;
    logic                   ext_src_reg;

    // Strap-like pin, not on clk
    always_ff @(posedge clk) begin
        nv_valid_meta <= nv_valid;
        nv_valid_sync <= nv_valid_meta;
    end

    cpm_nvstore u_nv (
        .clk   (clk),
        .we    (nv_we),
        .addr  (nv_addr),
        .wdata (nv_wdata),
        .rdata (nv_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Shared decodes for the write path and control outputs; the read mux decodes addr on its own
    function automatic logic addr_hit(input logic [9:0] a, input logic [9:0] reg_addr);
        return a == reg_addr;
    endfunction : addr_hit

    function automatic logic [1:0] pwr_field(input logic [7:0] v);
        return v[cpm_pkg::PLL_PWR_LSB +: 2];
    endfunction : pwr_field

    // Writes land only in RUN, so a restore is never torn; a write in the save request cycle still lands
    assign wr_ok = wr_en && (state_reg == cpm_pkg::ST_RUN);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer: restore after reset, then run; save takes two cycles
    always_comb begin
        nv_we    = 1'b0;
        nv_addr  = cpm_pkg::NV_IDX_PLL;
        nv_wdata = pll_ctrl_reg;
        unique case (state_reg)
            cpm_pkg::ST_LOAD0: begin
                // Reset reads word0 so it is ready at the first edge after release
                nv_addr = rst ? cpm_pkg::NV_IDX_PLL : cpm_pkg::NV_IDX_DIST;
            end
            cpm_pkg::ST_LOAD1: nv_addr = cpm_pkg::NV_IDX_DIST;
            cpm_pkg::ST_RUN: begin
                nv_we = nv_save;
            end
            cpm_pkg::ST_SAVE1: begin
                nv_we    = 1'b1;
                nv_addr  = cpm_pkg::NV_IDX_DIST;
                nv_wdata = dist_src_reg;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= cpm_pkg::ST_LOAD0;
        end else begin
            unique case (state_reg)
                cpm_pkg::ST_LOAD0: state_reg <= cpm_pkg::ST_LOAD1;
                cpm_pkg::ST_LOAD1: state_reg <= cpm_pkg::ST_RUN;
                cpm_pkg::ST_RUN: begin
                    if (nv_save) begin
                        state_reg <= cpm_pkg::ST_SAVE1;
                    end
                end
                cpm_pkg::ST_SAVE1: state_reg <= cpm_pkg::ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers; host writes ignored outside RUN so restore cannot be torn
    always_ff @(posedge clk) begin
        if (rst) begin
            pll_ctrl_reg <= cpm_pkg::RST_PLL_CTRL;
        end else if (state_reg == cpm_pkg::ST_LOAD0 && nv_valid_sync) begin
            pll_ctrl_reg <= nv_rdata;
        end else if (wr_ok && addr_hit(addr, cpm_pkg::ADDR_PLL_CTRL)) begin
            pll_ctrl_reg <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dist_src_reg <= cpm_pkg::RST_DIST_SRC;
        end else if (state_reg == cpm_pkg::ST_LOAD1 && nv_valid_sync) begin
            dist_src_reg <= nv_rdata;
        end else if (wr_ok && addr_hit(addr, cpm_pkg::ADDR_DIST_SRC)) begin
            dist_src_reg <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            unique case (addr)
                cpm_pkg::ADDR_PLL_CTRL: rdata <= pll_ctrl_reg;
                cpm_pkg::ADDR_DIST_SRC: rdata <= dist_src_reg;
                default:                rdata <= 8'h00;
            endcase
        end
    end

    // Busy rises the cycle after a save request and stays high one cycle past SAVE1
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b1;
        end else begin
            busy <= (state_reg != cpm_pkg::ST_RUN) || nv_save || (state_reg == cpm_pkg::ST_SAVE1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control outputs, one flop per concern
    // Codes 10/11 drive neither enable nor power-down: fail safe
    always_ff @(posedge clk) begin
        if (rst) begin
            pll_on_reg <= 1'b0;
        end else begin
            pll_on_reg <= pwr_field(pll_ctrl_reg) == cpm_pkg::PWR_NORMAL;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pll_off_reg <= 1'b1;
        end else begin
            pll_off_reg <= pwr_field(pll_ctrl_reg) == cpm_pkg::PWR_ASYNC_DOWN;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pump_mode_reg <= 2'h0;
        end else begin
            pump_mode_reg <= pll_ctrl_reg[cpm_pkg::CP_MODE_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pol_neg_reg <= 1'b0;
        end else begin
            pol_neg_reg <= pll_ctrl_reg[cpm_pkg::PFD_POL_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bypass_reg <= 1'b0;
        end else begin
            bypass_reg <= dist_src_reg[cpm_pkg::BYPASS_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ext_src_reg <= 1'b0;
        end else begin
            ext_src_reg <= ~dist_src_reg[cpm_pkg::SRC_SEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output struct taken straight from the flops above, no logic between
    assign ctrl = '{
        pll_enable:     pll_on_reg,
        pll_power_down: pll_off_reg,
        cp_mode:        pump_mode_reg,
        pfd_negative:   pol_neg_reg,
        div_bypass:     bypass_reg,
        src_ext_clk:    ext_src_reg
    };

endmodule : cpm_clock_path

//--- bench/cpm_clock_path_asserts.sv
module cpm_checker (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  wr_en,
    input wire logic                  rd_en,
    input wire logic [9:0]            addr,
    input wire logic [7:0]            wdata,
    input wire logic                  nv_save,
    input wire logic                  nv_valid,
    input wire logic [7:0]            rdata,
    input wire logic                  busy,
    input wire cpm_pkg::cpm_ctrl_type ctrl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wp;
    logic wd;
    // Accepted writes only: busy low implies RUN, where writes land
    assign wp = wr_en && !busy && addr == cpm_pkg::ADDR_PLL_CTRL;
    assign wd = wr_en && !busy && addr == cpm_pkg::ADDR_DIST_SRC;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_pwr_dn; wp && wdata[1:0] == 2'h1 |-> ##2 ctrl.pll_power_down && !ctrl.pll_enable; endproperty
    a_pwr_dn: assert property (p_pwr_dn) else $error("pll not powered down");
    property p_pwr_on; wp && wdata[1:0] == 2'h0 |-> ##2 ctrl.pll_enable && !ctrl.pll_power_down; endproperty
    a_pwr_on: assert property (p_pwr_on) else $error("pll not enabled");
    property p_pol; wp |-> ##2 ctrl.pfd_negative == $past(wdata[7], 2); endproperty
    a_pol: assert property (p_pol) else $error("polarity wrong");
    property p_byp; wd && wdata[0] |-> ##2 ctrl.div_bypass; endproperty
    a_byp: assert property (p_byp) else $error("bypass not set");
    property p_div; wd && !wdata[0] |-> ##2 !ctrl.div_bypass; endproperty
    a_div: assert property (p_div) else $error("divider not in path");
    property p_src; wd |-> ##2 ctrl.src_ext_clk == !$past(wdata[1], 2); endproperty
    a_src: assert property (p_src) else $error("source select wrong");
    // Restore may move ctrl, so only idle spans count
    property p_still; (!wr_en && !busy) [*3] |=> $stable(ctrl); endproperty
    a_still: assert property (p_still) else $error("ctrl moved without write");
    property p_boot; $fell(rst) |-> busy [*2] ##[1:3] !busy; endproperty
    a_boot: assert property (p_boot) else $error("restore sequence length wrong");
    c_save: cover property (nv_save && !busy ##1 busy);
    c_boot: cover property ($fell(rst) && nv_valid);
    c_byp: cover property (ctrl.div_bypass && !ctrl.src_ext_clk);
endmodule : cpm_checker

//--- bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk = 1'h0, rst = 1'h1, wr_en = 1'h0, rd_en = 1'h0;
    logic                  nv_save = 1'h0, nv_valid = 1'h0, busy;
    logic [9:0]            addr = 10'h000;
    logic [7:0]            wdata = 8'h00, rdata, p, d;
    cpm_pkg::cpm_ctrl_type ctrl;
    int                    num_errors = 0, total_checks = 0;
    localparam logic [9:0] PA = cpm_pkg::ADDR_PLL_CTRL;
    localparam logic [9:0] DA = cpm_pkg::ADDR_DIST_SRC;
    always #50 clk = ~clk;
    cpm_clock_path cpm_clock_path_i (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .nv_save(nv_save), .nv_valid(nv_valid),
        .rdata(rdata), .busy(busy), .ctrl(ctrl));
    ////////////////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task cmp8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp8
    task cmp_ctrl(input cpm_pkg::cpm_ctrl_type got, input cpm_pkg::cpm_ctrl_type exp);
        cmp8({1'h0, got}, {1'h0, exp});
    endtask : cmp_ctrl
    function cpm_pkg::cpm_ctrl_type ex(input logic [7:0] pv, input logic [7:0] dv);
        return {pv[1:0] == 2'h0, pv[1:0] == 2'h1, pv[3:2], pv[7], dv[0], !dv[1]};
    endfunction : ex
    task wr(input logic [9:0] a, input logic [7:0] v);
        @(negedge clk);
        wr_en = 1'h1; addr = a; wdata = v;
        @(negedge clk);
        wr_en = 1'h0;
    endtask : wr
    task rd(input logic [9:0] a, input logic [7:0] e);
        @(negedge clk);
        rd_en = 1'h1; addr = a;
        @(negedge clk);
        rd_en = 1'h0;
        cmp8(rdata, e);
    endtask : rd
    task idle;
        for (int k = 0; k < 20; k++) begin
            @(negedge clk);
            if (busy === 1'h0) return;
        end
        num_errors++;
        $display("CHECK FAILED t=%0t busy stuck", $time);
        wrap_up;
    endtask : idle
    // Reset held three cycles so nv_valid clears its two-flop synchronizer before release
    task boot(input logic v);
        rst = 1'h1; nv_valid = v;
        repeat (3) @(negedge clk);
        rst = 1'h0;
        idle;
    endtask : boot
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        boot(1'h0);
        rd(PA, 8'h01);
        rd(DA, 8'h00);
        rd(10'h3ff, 8'h00);
        cmp_ctrl(ctrl, ex(8'h01, 8'h00));
        for (int i = 0; i < 4; i++) begin
            p = {i[0], 3'h0, i[1:0], i[1:0]};
            d = {6'h00, i[1:0]};
            wr(PA, p);
            wr(DA, d);
            @(negedge clk);
            cmp_ctrl(ctrl, ex(p, d));
            rd(PA, p);
        end
        wr(PA, 8'h80);
        wr(DA, 8'h01);
        @(negedge clk);
        nv_save = 1'h1;
        @(negedge clk);
        nv_save = 1'h0;
        idle;
        wr(PA, 8'h01);
        wr(DA, 8'h02);
        boot(1'h1);
        rd(PA, 8'h80);
        rd(DA, 8'h01);
        cmp_ctrl(ctrl, ex(8'h80, 8'h01));
        wrap_up;
    end
endmodule : testbench
bind cpm_clock_path cpm_checker cpm_checker_i (.clk(clk), .rst(rst), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .nv_save(nv_save), .nv_valid(nv_valid),
    .rdata(rdata), .busy(busy), .ctrl(ctrl));
